//--- src/bmag_cfg.svh
// named constants for the bit-manipulation execution unit, group a
// assumes inclusion by bare name from the package and the unit
`ifndef BMAG_CFG_SVH
`define BMAG_CFG_SVH

// register widths that the unit supports
`define BMAG_XLEN_NARROW   32
`define BMAG_XLEN_WIDE     64
`define BMAG_DATA_W        64
// low word of an operand
`define BMAG_WORD_MSB      31
`define BMAG_WORD_W        32
// bit of the immediate index that is reserved in the narrow configuration
`define BMAG_IMM_RSVD_BIT  5
`define BMAG_IMM_W         6
// width of the operation select
`define BMAG_OP_W          5
// reset value of the answer
`define BMAG_RESULT_RST    64'h0000_0000_0000_0000

`endif

//--- src/bmag_pkg.sv
// types shared by the bit-manipulation execution unit, group a
// assumes bmag_cfg.svh is on the include path
`include "bmag_cfg.svh"

package bmag_pkg;

  // operation select from the execute stage
  typedef enum logic [`BMAG_OP_W-1:0] {
    BMAG_OP_ADD_ZERO_EXTENDED_WORD = 5'h00,
    BMAG_OP_AND_INV                = 5'h01,
    BMAG_OP_BIT_CLEAR              = 5'h02,
    BMAG_OP_BIT_EXTRACT            = 5'h03,
    BMAG_OP_BIT_INVERT             = 5'h04,
    BMAG_OP_BIT_SET                = 5'h05,
    BMAG_OP_BIT_CLEAR_IMM          = 5'h06,
    BMAG_OP_BIT_EXTRACT_IMM        = 5'h07,
    BMAG_OP_BIT_INVERT_IMM         = 5'h08,
    BMAG_OP_BIT_SET_IMM            = 5'h09,
    BMAG_OP_CLMUL_LOW              = 5'h0a,
    BMAG_OP_CLMUL_HIGH             = 5'h0b,
    BMAG_OP_CLMUL_REV              = 5'h0c,
    BMAG_OP_LEAD_ZERO              = 5'h0d,
    BMAG_OP_LEAD_ZERO_WORD         = 5'h0e,
    BMAG_OP_POP_COUNT              = 5'h0f,
    BMAG_OP_POP_COUNT_WORD         = 5'h10
  } bmag_op_t;

  // request from the execute stage
  typedef struct packed {
    logic                    valid;
    bmag_op_t                op;
    logic [`BMAG_IMM_W-1:0]  imm_index;
  } bmag_req_t;

  // answer to writeback; data above the register width reads zero
  typedef struct packed {
    logic                    valid;
    logic                    illegal;
    logic [`BMAG_DATA_W-1:0] data;
  } bmag_resp_t;

endpackage : bmag_pkg

//--- src/bmag_alu.sv
// bit-manipulation execution unit, group a: word add, and-not, single-bit
// ops, carry-less multiply, leading-zero count and population count
// assumes the execute stage holds operands for the cycle of req.valid and
// takes the registered answer one clock later
`timescale 1ns/100ps
`include "bmag_cfg.svh"

// Behaviour
// - add zero-extended low word to second operand
// - and first operand with inverted second
// - register index uses low log2 bits
// - clear: force selected bit to zero
// - extract: selected bit into bit zero
// - invert: toggle selected bit only
// - set: force selected bit to one
// - immediate forms take index from immediate
// - narrow: immediate index bit five reserved
// - carry-less multiply returns low product half
// - carry-less multiply high returns upper half
// - reversed returns product bits 2w-2 to w-1
// - reversed equals reversed operands low product
// - leading zeros full width, width when zero
// - word leading zeros from bit 31
// - population count over whole operand
// - word population count over low word
module bmag_alu #(
  parameter int XLEN = `BMAG_XLEN_WIDE
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // request from the execute stage
  input  wire bmag_pkg::bmag_req_t      req,
  input  wire logic [XLEN-1:0]          first_source_operand,
  input  wire logic [XLEN-1:0]          second_source_operand,
  // answer to writeback
  output bmag_pkg::bmag_resp_t          resp_q
);

  // width of a bit index, and of a count that must also hold the width
  // itself for an all-zero operand
  localparam int IDX_W = $clog2(XLEN);
  localparam int CNT_W = IDX_W + 1;
  // only the wide configuration offers the word operations
  localparam bit WIDE  = (XLEN == `BMAG_XLEN_WIDE);

  // operands under short names
  logic [XLEN-1:0]   a;
  logic [XLEN-1:0]   b;
  // bit index and its one-hot mask
  logic [IDX_W-1:0]  reg_index;
  logic [IDX_W-1:0]  imm_index;
  logic [IDX_W-1:0]  bit_index;
  logic [XLEN-1:0]   bit_mask;
  // decode of the select
  logic              imm_form;
  logic              imm_reserved;
  logic              wide_only;
  logic              op_known;
  // add and logic
  logic [XLEN-1:0]   sum_word;
  logic [XLEN-1:0]   and_inv;
  // carry-less multiply
  logic [XLEN-1:0]   pp [XLEN];
  logic [2*XLEN-1:0] clmul_acc [XLEN+1];
  logic [2*XLEN-1:0] clmul_prod;
  logic [XLEN-1:0]   clmul_low;
  logic [XLEN-1:0]   clmul_high;
  logic [XLEN-1:0]   clmul_rev;
  // counts; chain entry i covers operand bits i-1 down to 0
  logic [CNT_W-1:0]  lz_acc [XLEN+1];
  logic [CNT_W-1:0]  lzw_acc [`BMAG_WORD_W+1];
  logic [CNT_W-1:0]  pop_acc [XLEN+1];
  logic [CNT_W-1:0]  lz_full;
  logic [CNT_W-1:0]  lz_word;
  logic [CNT_W-1:0]  pop_full;
  logic [CNT_W-1:0]  pop_word;
  // answer
  logic [XLEN-1:0]   result;
  logic              illegal;
  bmag_pkg::bmag_resp_t resp_d;

  assign a = first_source_operand;
  assign b = second_source_operand;

  // index selection; higher bits of the source are simply not wired in
  // low index bits
  assign reg_index = b[IDX_W-1:0];
  assign imm_index = req.imm_index[IDX_W-1:0];

  // immediate single-bit forms
  always_comb begin
    case (req.op)
      bmag_pkg::BMAG_OP_BIT_CLEAR_IMM,
      bmag_pkg::BMAG_OP_BIT_EXTRACT_IMM,
      bmag_pkg::BMAG_OP_BIT_INVERT_IMM,
      bmag_pkg::BMAG_OP_BIT_SET_IMM: imm_form = 1'b1;
      default:                       imm_form = 1'b0;
    endcase
  end

  assign bit_index = imm_form ? imm_index : reg_index;

  // one-hot mask at the selected index
  assign bit_mask = {{(XLEN-1){1'b0}}, 1'b1} << bit_index;

  // a size cast zero-extends, and unlike a filler replication it stays
  // legal in the narrow configuration, where the filler has no bits
  // zero-extended word add
  assign sum_word = b + XLEN'(a[`BMAG_WORD_MSB:0]);

  assign and_inv = a & ~b;

  // chain seeds: entry 0 is the value for an empty operand
  assign clmul_acc[0] = '0;
  assign lz_acc[0]    = CNT_W'(XLEN);
  assign lzw_acc[0]   = CNT_W'(`BMAG_WORD_W);
  assign pop_acc[0]   = '0;

  // one slice per operand bit moves every chain on by one place, the word chain in the low 32 slices only; ripple
  // chains keep the netlist plain, and as each step is associative a
  // synthesis tool may rebalance them into trees where timing needs it
  for (genvar i = 0; i < XLEN; i++) begin : g_bit
    // partial product: a itself where bit i of b is set
    assign pp[i]          = b[i] ? a : '0;
    // xor-accumulate at offset i; columns never carry into each other
    assign clmul_acc[i+1] = clmul_acc[i] ^ ({{XLEN{1'b0}}, pp[i]} << i);
    // scanning up from the lsb, the highest one seen so far decides
    assign lz_acc[i+1]    = a[i] ? CNT_W'(XLEN - 1 - i) : lz_acc[i];
    // one-bit increment of the running population
    assign pop_acc[i+1]   = pop_acc[i] + CNT_W'(a[i]);
    // the low word has its own leading-zero chain, counted from bit 31
    if (i < `BMAG_WORD_W) begin : g_word
      assign lzw_acc[i+1] = a[i] ? CNT_W'(`BMAG_WORD_MSB - i) : lzw_acc[i];
    end
  end

  // the product is kept at double width so all three slices share it
  assign clmul_prod = clmul_acc[XLEN];
  assign clmul_low  = clmul_prod[XLEN-1:0];
  assign clmul_high = clmul_prod[2*XLEN-1:XLEN];
  // middle slice, which is the bit-reversed low product of the
  // bit-reversed operands, so no second multiplier is needed
  // reversal equivalence
  assign clmul_rev  = clmul_prod[2*XLEN-2:XLEN-1];

  // counts are the chain ends, or taps part-way along them
  // full-width leading zeros
  assign lz_full  = lz_acc[XLEN];
  assign lz_word  = lzw_acc[`BMAG_WORD_W];
  assign pop_full = pop_acc[XLEN];
  // the word form taps the same chain after bit 31, so it costs no
  // adders of its own
  // low word population
  assign pop_word = pop_acc[`BMAG_WORD_W];

  // legality of the select for this configuration
  // wide-only operations
  always_comb begin
    case (req.op)
      bmag_pkg::BMAG_OP_ADD_ZERO_EXTENDED_WORD,
      bmag_pkg::BMAG_OP_LEAD_ZERO_WORD,
      bmag_pkg::BMAG_OP_POP_COUNT_WORD: wide_only = 1'b1;
      default:                          wide_only = 1'b0;
    endcase
  end

  // select codes past the last operation are refused as well
  assign op_known = (req.op <= bmag_pkg::BMAG_OP_POP_COUNT_WORD);

  assign imm_reserved = !WIDE && imm_form && req.imm_index[`BMAG_IMM_RSVD_BIT];

  assign illegal = !op_known || imm_reserved || (wide_only && !WIDE);

  // result multiplexer; a refused request answers zero, never a partial
  // result, so writeback can discard it without side effects
  always_comb begin
    result = '0;
    case (req.op)
      bmag_pkg::BMAG_OP_ADD_ZERO_EXTENDED_WORD: result = sum_word;
      bmag_pkg::BMAG_OP_AND_INV:                result = and_inv;
      bmag_pkg::BMAG_OP_BIT_CLEAR,
      bmag_pkg::BMAG_OP_BIT_CLEAR_IMM:          result = a & ~bit_mask;
      bmag_pkg::BMAG_OP_BIT_EXTRACT,
      bmag_pkg::BMAG_OP_BIT_EXTRACT_IMM:        result = {{(XLEN-1){1'b0}}, a[bit_index]};
      bmag_pkg::BMAG_OP_BIT_INVERT,
      bmag_pkg::BMAG_OP_BIT_INVERT_IMM:         result = a ^ bit_mask;
      bmag_pkg::BMAG_OP_BIT_SET,
      bmag_pkg::BMAG_OP_BIT_SET_IMM:            result = a | bit_mask;
      bmag_pkg::BMAG_OP_CLMUL_LOW:              result = clmul_low;
      bmag_pkg::BMAG_OP_CLMUL_HIGH:             result = clmul_high;
      bmag_pkg::BMAG_OP_CLMUL_REV:              result = clmul_rev;
      bmag_pkg::BMAG_OP_LEAD_ZERO:              result = XLEN'(lz_full);
      bmag_pkg::BMAG_OP_LEAD_ZERO_WORD:         result = XLEN'(lz_word);
      bmag_pkg::BMAG_OP_POP_COUNT:              result = XLEN'(pop_full);
      bmag_pkg::BMAG_OP_POP_COUNT_WORD:         result = XLEN'(pop_word);
      default:                                  result = '0;
    endcase
    if (illegal) begin
      result = '0;
    end
  end

  // pack the answer; bits above the register width stay zero
  always_comb begin
    resp_d         = '0;
    resp_d.valid   = req.valid;
    resp_d.illegal = req.valid && illegal;
    resp_d.data    = (req.valid && !illegal) ? `BMAG_DATA_W'(result) : '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_q <= '{valid: 1'b0, illegal: 1'b0, data: `BMAG_RESULT_RST};
    end else begin
      resp_q <= resp_d;
    end
  end

endmodule : bmag_alu

//--- bench/bmag_exec_model.sv
// execute-stage model that feeds operands and a select to the unit
// assumes the bench calls send and idle from a single process
`timescale 1ns/100ps
module bmag_exec_model #(
  parameter int XLEN = 64
) (
  // clock
  input  wire logic           clk,
  // request to the unit
  output bmag_pkg::bmag_req_t req,
  output logic [XLEN-1:0]     a,
  output logic [XLEN-1:0]     b
);
  // quiet request at time zero
  initial begin
    req = '0;
    a = '0;
    b = '0;
  end

  task automatic send(input logic [4:0] op, input logic [XLEN-1:0] x,
                      input logic [XLEN-1:0] y, input logic [5:0] imm);
    @(negedge clk);
    req = '{valid: 1'b1, op: bmag_pkg::bmag_op_t'(op), imm_index: imm};
    a = x;
    b = y;
  endtask : send

  // stale operands flip so nothing leans on them
  task automatic idle();
    @(negedge clk);
    req.valid = 1'b0;
    a = ~a;
    b = ~b;
  endtask : idle
endmodule : bmag_exec_model

//--- bench/bmag_alu_props.sv
// port assertions for the bit-manipulation unit, either configuration
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/100ps
module bmag_alu_props #(
  parameter int XLEN = 64
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // request and answer
  input wire bmag_pkg::bmag_req_t  req,
  input wire logic [XLEN-1:0]      first_source_operand,
  input wire logic [XLEN-1:0]      second_source_operand,
  input wire bmag_pkg::bmag_resp_t resp_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  localparam int IDX_W = $clog2(XLEN);
  // short aliases keep the properties readable
  wire [XLEN-1:0] a = first_source_operand;
  wire [XLEN-1:0] b = second_source_operand;
  wire [4:0]      op = req.op;
  wire            v = req.valid;
  wire [63:0]     d = resp_q.data;

  a_answer_follows: assert property (v |=> resp_q.valid)
    else $error("no answer one cycle after a request");
  a_idle_quiet: assert property (!v |=> resp_q == '0)
    else $error("answer not quiet after an idle cycle");
  a_word_add: assert property (v && op == 5'h00
    |=> d == $past(XLEN == 64 ? b + {32'h0, a[31:0]} : 64'h0))
    else $error("word add result wrong");
  a_and_inverted: assert property (v && op == 5'h01 |=> d == $past(a & ~b))
    else $error("and with inverted operand wrong");
  a_bit_set_reg: assert property (v && op == 5'h05
    |=> d == $past(a | (64'h1 << b[IDX_W-1:0])))
    else $error("register bit set wrong");
  a_clear_imm: assert property (v && op == 5'h06
    |=> d == $past(XLEN == 32 && req.imm_index[5] ? 64'h0
                   : a & ~(64'h1 << req.imm_index[IDX_W-1:0])))
    else $error("immediate bit clear wrong");
  a_word_pop: assert property (v && op == 5'h10
    |=> d == $past(XLEN == 64 ? 64'($countones(a[31:0])) : 64'h0))
    else $error("word population count wrong");
  a_lead_zero_all: assert property (v && op == 5'h0d && a == '0 |=> d == XLEN)
    else $error("leading zeros of zero is not the width");
endmodule : bmag_alu_props

bind bmag_alu bmag_alu_props #(.XLEN(XLEN)) u_bmag_alu_props (
  .clk(clk), .rst_n(rst_n), .req(req), .first_source_operand(first_source_operand),
  .second_source_operand(second_source_operand), .resp_q(resp_q));

//--- bench/tb_bmag_alu.sv
// self-checking bench for the bit-manipulation unit, both configurations
// assumes the unit answers exactly one clock after each request
`timescale 1ns/100ps
module tb_bmag_alu;
  // one row: select, operands, immediate, expected data
  typedef struct packed {
    logic [4:0]  op;
    logic [63:0] a;
    logic [63:0] b;
    logic [5:0]  imm;
    logic [63:0] exp;
  } bmag_row_t;
  `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end

  logic                 clk;
  logic                 rst_n;
  bmag_pkg::bmag_req_t  req;
  logic [63:0]          a;
  logic [63:0]          b;
  bmag_pkg::bmag_resp_t resp_q;
  bmag_pkg::bmag_resp_t resp_narrow;
  int                   n_errors = 0;
  int                   compares = 0;
  bmag_row_t rows [19] = '{
    '{5'h00, 64'hffffffff80000001, 64'h1, 6'h0, 64'h80000002},
    '{5'h01, 64'hf0f0, 64'hff00, 6'h0, 64'hf0},
    '{5'h02, ~64'h0, 64'h13f, 6'h0, 64'h7fffffffffffffff},
    '{5'h03, 64'h8, 64'h43, 6'h0, 64'h1},
    '{5'h04, 64'h0, 64'h40, 6'h0, 64'h1},
    '{5'h05, 64'h0, 64'h3f, 6'h0, 64'h8000000000000000},
    '{5'h06, ~64'h0, 64'h0, 6'h3f, 64'h7fffffffffffffff},
    '{5'h07, 64'h4, 64'h0, 6'h2, 64'h1},
    '{5'h08, 64'h0, 64'h0, 6'h1, 64'h2},
    '{5'h09, 64'h0, 64'h0, 6'h20, 64'h100000000},
    '{5'h0a, 64'h3, 64'h3, 6'h0, 64'h5},
    '{5'h0b, 64'h8000000000000000, 64'h2, 6'h0, 64'h1},
    '{5'h0c, 64'h3, 64'h4000000000000000, 6'h0, 64'h1},
    '{5'h0d, 64'h0, 64'h0, 6'h0, 64'h40},
    '{5'h0e, 64'hffffffff00000000, 64'h0, 6'h0, 64'h20},
    '{5'h0e, 64'h80000000, 64'h0, 6'h0, 64'h0},
    '{5'h0f, ~64'h0, 64'h0, 6'h0, 64'h40},
    '{5'h0f, 64'h8000000000000000, 64'h0, 6'h0, 64'h1},
    '{5'h10, 64'hffff000000000003, 64'h0, 6'h0, 64'h2}};

  bmag_exec_model #(.XLEN(64)) u_bmag_exec_model (.clk(clk), .req(req), .a(a), .b(b));
  bmag_alu #(.XLEN(64)) u_bmag_alu (.clk(clk), .rst_n(rst_n), .req(req),
    .first_source_operand(a), .second_source_operand(b), .resp_q(resp_q));
  // narrow copy on the low operand bits, for the 32-bit refusals and index checks
  bmag_alu #(.XLEN(32)) u_bmag_alu_narrow (.clk(clk), .rst_n(rst_n), .req(req),
    .first_source_operand(a[31:0]), .second_source_operand(b[31:0]),
    .resp_q(resp_narrow));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // counts, verdict and end of run
  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // cut a hang short
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  // table back to back, then refusal, idle and a reset in mid-run
  initial begin
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(posedge clk);
    #1 `CHK("first edge after reset", 66'h0, resp_q)
    foreach (rows[i]) begin
      u_bmag_exec_model.send(rows[i].op, rows[i].a, rows[i].b, rows[i].imm);
      @(posedge clk);
      #1 `CHK("table row", {2'b10, rows[i].exp}, resp_q)
    end
    u_bmag_exec_model.send(5'h1f, ~64'h0, ~64'h0, 6'h3f);
    @(posedge clk);
    #1 `CHK("refused select", {2'b11, 64'h0}, resp_q)
    u_bmag_exec_model.send(5'h09, 64'h0, 64'h0, 6'h20);
    @(posedge clk);
    #1 `CHK("wide set index 32", {2'b10, 64'h100000000}, resp_q)
    `CHK("narrow reserved index", {2'b11, 64'h0}, resp_narrow)
    u_bmag_exec_model.send(5'h09, 64'h0, 64'h0, 6'h1f);
    @(posedge clk);
    #1 `CHK("narrow set index 31", {2'b10, 64'h80000000}, resp_narrow)
    u_bmag_exec_model.send(5'h02, ~64'h0, 64'h3f, 6'h0);
    @(posedge clk);
    #1 `CHK("narrow low index bits", {2'b10, 64'h7fffffff}, resp_narrow)
    u_bmag_exec_model.send(5'h10, ~64'h0, 64'h0, 6'h0);
    @(posedge clk);
    #1 `CHK("narrow word op refused", {2'b11, 64'h0}, resp_narrow)
    u_bmag_exec_model.idle();
    @(posedge clk);
    #1 `CHK("idle answer", 66'h0, resp_q)
    u_bmag_exec_model.send(5'h0f, ~64'h0, 64'h0, 6'h0);
    @(posedge clk);
    #1 `CHK("count before reset", {2'b10, 64'h40}, resp_q)
    @(negedge clk) rst_n = 1'b0;
    #1 `CHK("answer in reset", 66'h0, resp_q)
    u_bmag_exec_model.idle();
    @(negedge clk) rst_n = 1'b1;
    @(posedge clk);
    #1 `CHK("edge after second reset", 66'h0, resp_q)
    u_bmag_exec_model.send(5'h0f, 64'h3, 64'h0, 6'h0);
    @(posedge clk);
    #1 `CHK("answer after second reset", {2'b10, 64'h2}, resp_q)
    print_verdict();
  end
endmodule : tb_bmag_alu
